// [src/dmc_pkg.sv]
// Functional notes
// - Nine row bits captured on row strobe fall
// - Nine column bits captured on column strobe fall
// - Every row refreshed within each 4 ms
// - Column strobe stays high during refresh
// - Host pulls presence high, presence only
// - Writes may mix into page-mode reads
// - Reads may mix into page-mode writes
// - Late-write output levels are ignored
// - Write-enable high reads, low writes
package dmc_pkg;
    localparam int ADDR_W = 9;
    localparam int DATA_W = 8;
    localparam int WORDS = 262144;
    localparam int ROWS = 256;
    localparam int CLK_MHZ = 125;
    localparam int REFRESH_MS = 4;
    localparam int REFRESH_CYC = (REFRESH_MS * 1000 * CLK_MHZ) / ROWS;
    localparam int RAS_LOW_NS = 150;
    localparam int RAS_LOW_CYC = (RAS_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int RAS_HIGH_NS = 100;
    localparam int RAS_HIGH_CYC = (RAS_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int RCD_NS = 30;
    localparam int RCD_CYC = (RCD_NS * CLK_MHZ + 999) / 1000;
    localparam int CAS_LOW_NS = 75;
    localparam int CAS_LOW_CYC = (CAS_LOW_NS * CLK_MHZ + 999) / 1000;
    localparam int CAS_HIGH_NS = 60;
    localparam int CAS_HIGH_CYC = (CAS_HIGH_NS * CLK_MHZ + 999) / 1000;
    localparam int TMR_W = 12;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;

    typedef enum logic [2:0] {
        DMC_IDLE   = 3'b000,
        DMC_ROW    = 3'b001,
        DMC_CASLO  = 3'b011,
        DMC_CASHI  = 3'b010,
        DMC_PRE    = 3'b110,
        DMC_REFROW = 3'b100
    } dmc_state_t;

    typedef struct packed {
        logic              write;
        logic [17:0]       addr;
        logic [DATA_W-1:0] wdata;
    } dmc_req_t;

    typedef struct packed {
        logic              rasN;
        logic              casN;
        logic              weN;
        logic [ADDR_W-1:0] addr;
        logic [DATA_W-1:0] dqOut;
        logic              dqOe;
    } dmc_pins_t;
endpackage

// [src/dmc_host.sv]
`timescale 1ns/100ps
`default_nettype none
module dmc_host
    import dmc_pkg::*;
#(
    parameter int REFRESH_CYCLES = REFRESH_CYC
) (
    input  wire logic              clk,
    input  wire logic              reset_n,
    input  wire logic              reqValid,
    output logic                   reqReady,
    input  wire dmc_req_t          req,
    output logic                   rdValid,
    output logic [DATA_W-1:0]      rdData,
    output logic                   modulePresent,
    input  wire logic              module_present_n,
    output logic                   rowStrobeN,
    output logic                   colStrobeN,
    output logic                   writeEnableN,
    output logic [ADDR_W-1:0]      addrOut,
    input  wire logic [DATA_W-1:0] shared_data_lines_in,
    output logic [DATA_W-1:0]      shared_data_lines_out,
    output logic                   shared_data_lines_oe
);
    typedef struct packed {
        dmc_state_t        st;
        dmc_pins_t         pins;
        logic [TMR_W-1:0]  tmr;
        logic [31:0]       refTmr;
        logic              refDue;
        logic [7:0]        refRow;
        dmc_req_t          cur;
        logic              rdValid;
        logic [DATA_W-1:0] rdData;
        logic [DATA_W-1:0] dqS1;
        logic [DATA_W-1:0] dqS2;
        logic [1:0]        prs;
    } dmc_st_t;

    dmc_st_t s;
    dmc_st_t next_s;

    function automatic logic [TMR_W-1:0] cyc(input int n);
        cyc = TMR_W'(n - 1);
    endfunction

    assign reqReady = (s.st == DMC_IDLE) && !s.refDue && reset_n;
    assign rowStrobeN = s.pins.rasN;
    assign colStrobeN = s.pins.casN;
    assign writeEnableN = s.pins.weN;
    assign addrOut = s.pins.addr;
    assign shared_data_lines_out = s.pins.dqOut;
    assign shared_data_lines_oe = s.pins.dqOe;
    assign rdValid = s.rdValid;
    assign rdData = s.rdData;
    assign modulePresent = !s.prs[1];

    always_comb begin
        next_s = s;
        next_s.rdValid = 1'b0;
        next_s.dqS1 = shared_data_lines_in;
        next_s.dqS2 = s.dqS1;
        next_s.prs = {s.prs[0], module_present_n};
        if (s.tmr != '0) begin
            next_s.tmr = s.tmr - TMR_W'(1);
        end
        case (s.st)
            DMC_IDLE: begin
                // The row half goes out one cycle before the row strobe falls, so it never races the edge.
                if (s.refDue) begin
                    next_s.refDue = 1'b0;
                    next_s.pins.addr = {1'b0, s.refRow};
                    next_s.tmr = cyc(RAS_LOW_CYC + 1);
                    next_s.st = DMC_REFROW;
                end else if (reqValid) begin
                    next_s.cur = req;
                    next_s.pins.addr = req.addr[17:9];
                    next_s.tmr = cyc(RCD_CYC + 1);
                    next_s.st = DMC_ROW;
                end
            end
            DMC_ROW: begin
                next_s.pins.rasN = 1'b0;
                next_s.pins.weN = !s.cur.write;
                next_s.pins.dqOut = s.cur.wdata;
                next_s.pins.dqOe = s.cur.write;
                if (s.tmr == '0) begin
                    next_s.pins.addr = s.cur.addr[8:0];
                    next_s.st = DMC_CASLO;
                    // The column strobe falls one cycle after this load, hence the extra count.
                    next_s.tmr = cyc(CAS_LOW_CYC + 1);
                end
            end
            DMC_CASLO: begin
                // address set a cycle before fall
                next_s.pins.casN = 1'b0;
                if (s.tmr == '0 && !s.pins.casN) begin
                    if (!s.cur.write) begin
                        next_s.rdData = s.dqS2;
                        next_s.rdValid = 1'b1;
                    end
                    next_s.pins.casN = 1'b1;
                    next_s.tmr = cyc(RAS_LOW_CYC);
                    next_s.st = DMC_CASHI;
                end
            end
            DMC_CASHI: begin
                if (s.tmr == '0) begin
                    next_s.pins.rasN = 1'b1;
                    next_s.pins.weN = 1'b1;
                    next_s.pins.dqOe = 1'b0;
                    next_s.tmr = cyc(RAS_HIGH_CYC);
                    next_s.st = DMC_PRE;
                end
            end
            DMC_REFROW: begin
                next_s.pins.rasN = 1'b0;
                if (s.tmr == '0) begin
                    next_s.pins.rasN = 1'b1;
                    next_s.refRow = s.refRow + 8'h01;
                    next_s.tmr = cyc(RAS_HIGH_CYC);
                    next_s.st = DMC_PRE;
                end
            end
            DMC_PRE: begin
                if (s.tmr == '0) begin
                    next_s.st = DMC_IDLE;
                end
            end
            default: next_s.st = DMC_IDLE;
        endcase
        // The timer sits after the state logic so that a wrap in the cycle of the idle clear keeps a refresh due.
        // periodic row refresh
        if (s.refTmr == 32'(REFRESH_CYCLES - 1)) begin
            next_s.refTmr = 32'h0;
            next_s.refDue = 1'b1;
        end else begin
            next_s.refTmr = s.refTmr + 32'h1;
        end
    end

    always_ff @(posedge clk) begin
        if (!reset_n) begin
            s <= '0;
            s.st <= DMC_IDLE;
            s.pins.rasN <= 1'b1;
            s.pins.casN <= 1'b1;
            s.pins.weN <= 1'b1;
            s.prs <= 2'b11;
        end else begin
            s <= next_s;
        end
    end

    refresh_cas_a: assert property (@(posedge clk) disable iff (!reset_n)
        s.st == DMC_REFROW |-> colStrobeN) else $error("column strobe low in refresh");
    early_write_a: assert property (@(posedge clk) disable iff (!reset_n)
        shared_data_lines_oe |-> !writeEnableN) else $error("data driven in read");
    row_capture_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(rowStrobeN) |-> $stable(addrOut)) else $error("row address moved at row strobe fall");
    // column strobe only under row strobe
    col_under_row_a: assert property (@(posedge clk) disable iff (!reset_n)
        !colStrobeN |-> !rowStrobeN) else $error("column without row");
    col_addr_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !colStrobeN && $past(!colStrobeN) |-> $stable(addrOut)) else $error("address moved");
    refresh_start_a: assert property (@(posedge clk) disable iff (!reset_n)
        $rose(s.refDue) |-> ##[1:60] s.st == DMC_REFROW) else $error("refresh late");
    read_pulse_a: assert property (@(posedge clk) disable iff (!reset_n)
        rdValid |=> !rdValid) else $error("read valid held");
    // write enable low only with row low
    we_level_a: assert property (@(posedge clk) disable iff (!reset_n)
        !writeEnableN |-> !rowStrobeN) else $error("write enable stray");

    // The counts below assume the 8 ns clock and the package timing constants.
    // column half settled at fall
    col_setup_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(colStrobeN) |-> $stable(addrOut)) else $error("column address moved at column strobe fall");
    cas_width_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(colStrobeN) |-> !colStrobeN [*8] ##1 !colStrobeN ##1 !colStrobeN)
        else $error("column strobe pulse too short");
    // write enable steady under column strobe
    we_stable_a: assert property (@(posedge clk) disable iff (!reset_n)
        !colStrobeN |-> $stable(writeEnableN)) else $error("write enable moved under column strobe");
    // write data steady under column strobe
    data_hold_a: assert property (@(posedge clk) disable iff (!reset_n)
        !colStrobeN && shared_data_lines_oe |-> $stable(shared_data_lines_out)) else $error("write data moved");
    refresh_addr_a: assert property (@(posedge clk) disable iff (!reset_n)
        $fell(rowStrobeN) && s.st == DMC_REFROW |-> !addrOut[8]) else $error("refresh row out of range");
    read_in_cas_a: assert property (@(posedge clk) disable iff (!reset_n)
        rdValid |-> !$past(colStrobeN)) else $error("read taken without column strobe");
    rd_only_read_a: assert property (@(posedge clk) disable iff (!reset_n)
        rdValid |-> writeEnableN) else $error("read result in write cycle");

    pre_ras_high_a: assert property (@(posedge clk) disable iff (!reset_n)
        s.st == DMC_PRE |-> rowStrobeN && colStrobeN) else $error("strobe low in precharge");
    idle_quiet_a: assert property (@(posedge clk) disable iff (!reset_n)
        s.st == DMC_IDLE |-> rowStrobeN && colStrobeN && writeEnableN && !shared_data_lines_oe)
        else $error("bus not released in idle");
    refresh_no_drive_a: assert property (@(posedge clk) disable iff (!reset_n)
        s.st == DMC_REFROW |-> writeEnableN && !shared_data_lines_oe) else $error("data driven in refresh");
endmodule
`default_nettype wire

// [sim/dmc_dram_model.sv]
`timescale 1ns/100ps
`default_nettype none
module dmc_dram_model
    import dmc_pkg::*;
(
    input  wire logic              rowStrobeN,
    input  wire logic              colStrobeN,
    input  wire logic              writeEnableN,
    input  wire logic [ADDR_W-1:0] addr,
    input  wire logic [DATA_W-1:0] dq,
    input  wire logic              hostOe,
    output logic [DATA_W-1:0]      dqOut,
    output logic                   dqOe,
    output logic                   presentN,
    output int                     refreshes,
    output int                     refreshSkips,
    output int                     clashes
);
    logic [DATA_W-1:0] mem [WORDS];
    logic [ADDR_W-1:0] row;
    logic [ADDR_W-1:0] col;
    logic [7:0]        nextRefRow;
    logic              rowActive;
    logic              casSeen;
    logic              casFirst;
    logic              earlyWrite;
    initial begin
        refreshes = 0;
        refreshSkips = 0;
        clashes = 0;
        nextRefRow = 8'h00;
        rowActive = 1'b0;
        casSeen = 1'b0;
        casFirst = 1'b0;
        earlyWrite = 1'b0;
    end
    assign presentN = 1'b0;
    // row capture; column-first cycle ignores the address
    always @(negedge rowStrobeN) begin
        rowActive = 1'b1;
        casSeen = 1'b0;
        casFirst = !colStrobeN;
        if (colStrobeN) row = addr;
    end
    // a row cycle with no column strobe refreshes the row on the address; a row out of turn counts a skip
    always @(posedge rowStrobeN) begin
        if (rowActive && (casFirst || !casSeen)) refreshes++;
        if (rowActive && !casFirst && !casSeen) begin
            if (row != {1'b0, nextRefRow}) refreshSkips++;
            nextRefRow = row[7:0] + 8'h01;
        end
        rowActive = 1'b0;
    end
    // column capture, latched write; later falls step the nibble
    always @(negedge colStrobeN) begin
        if (rowActive && !casFirst) begin
            if (casSeen) {row[8], col[8]} = {row[8], col[8]} + 2'b01;
            else col = addr;
            casSeen = 1'b1;
            earlyWrite = !writeEnableN;
            if (!writeEnableN) mem[{row, col}] = dq;
            dqOut = mem[{row, col}];
        end
    end
    // output only while both strobes low, never in an early write
    assign dqOe = !rowStrobeN && !colStrobeN && casSeen && !earlyWrite;
    always @(dqOe or hostOe) if (dqOe && hostOe) clashes++;
endmodule
`default_nettype wire

// [sim/dmc_host_bench.sv]
`timescale 1ns/100ps
`default_nettype none
module dmc_host_bench;
    import dmc_pkg::*;
    logic clk = 0, reset_n = 0, reqValid = 0, slotEmpty = 0;
    logic reqReady, rdValid, modulePresent, rasN, casN, weN, hostOe, devOe, presentN;
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] rdData, hostOut, devOut, dq, got;
    dmc_req_t req = '0;
    int failures = 0, numChecks = 0, refreshes, refreshSkips, clashes, r0;
    dmc_req_t cases [9] = '{'{1'b1, 18'h00000, 8'h11}, '{1'b1, 18'h3FFFF, 8'hEE}, '{1'b1, 18'h001FF, 8'h7C},
        '{1'b1, 18'h3FE00, 8'hC3}, '{1'b1, 18'h00000, 8'h22}, '{1'b0, 18'h00000, 8'h22},
        '{1'b0, 18'h3FFFF, 8'hEE}, '{1'b0, 18'h001FF, 8'h7C}, '{1'b0, 18'h3FE00, 8'hC3}};
    always #4 clk = ~clk;
    // Released lines show a pattern that changes, not the last value.
    always_comb dq = hostOe ? hostOut : devOe ? devOut : ({8{clk}} ^ 8'h3C);
    dmc_host #(.REFRESH_CYCLES(200)) u_dmc_host (.clk(clk), .reset_n(reset_n), .reqValid(reqValid),
        .reqReady(reqReady), .req(req), .rdValid(rdValid), .rdData(rdData), .modulePresent(modulePresent),
        .module_present_n(slotEmpty ? 1'b1 : presentN), .rowStrobeN(rasN), .colStrobeN(casN),
        .writeEnableN(weN), .addrOut(addr), .shared_data_lines_in(dq), .shared_data_lines_out(hostOut),
        .shared_data_lines_oe(hostOe));
    dmc_dram_model u_dmc_dram_model (.rowStrobeN(rasN), .colStrobeN(casN), .writeEnableN(weN),
        .addr(addr), .dq(dq), .hostOe(hostOe), .dqOut(devOut), .dqOe(devOe), .presentN(presentN),
        .refreshes(refreshes), .refreshSkips(refreshSkips), .clashes(clashes));
    task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
        numChecks++;
        if (seen !== exp) begin
            failures++;
            $display("MISMATCH %s expected %0h seen %0h", name, exp, seen);
        end
    endtask
    task automatic access(input dmc_req_t r, output logic [DATA_W-1:0] d);
        int n;
        @(negedge clk);
        reqValid = 1;
        req = r;
        n = 0;
        do @(posedge clk); while (!reqReady && ++n < 2000);
        check("reqTaken", reqReady, 1'b1);
        @(negedge clk);
        reqValid = 0;
        n = 0;
        if (!r.write) begin
            do @(posedge clk); while (!rdValid && ++n < 200);
            d = rdData;
            check("rdValid", rdValid, 1'b1);
        end
    endtask
    task end_sim;
        $display("checks %0d failures %0d", numChecks, failures);
        if (failures == 0 && numChecks > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    initial begin
        #(8 * 20000);
        failures++;
        end_sim();
    end
    initial begin
        repeat (3) @(negedge clk);
        reset_n = 1;
        foreach (cases[i]) begin
            access(cases[i], got);
            if (!cases[i].write) check("rdData", got, cases[i].wdata);
        end
        check("clashes", clashes, 0);
        r0 = refreshes;
        repeat (1000) @(negedge clk);
        check("refreshGrowth", (refreshes - r0) >= 4, 1);
        check("refreshSkips", refreshSkips, 0);
        check("modulePresent", modulePresent, 1'b1);
        slotEmpty = 1;
        repeat (4) @(negedge clk);
        check("emptySlot", modulePresent, 1'b0);
        slotEmpty = 0;
        reqValid = 1;
        req = cases[1];
        reset_n = 0;
        repeat (3) @(negedge clk);
        check("resetPins", {rasN, casN, hostOe, rdValid, reqReady}, 5'b11000);
        reqValid = 0;
        reset_n = 1;
        access(cases[6], got);
        check("afterReset", got, 8'hEE);
        end_sim();
    end
endmodule
`default_nettype wire
